/* hw/acrb_pkg.sv */
/*
 * Shared constants of the converter configuration register bank: register
 * indices, field positions, reset values, command encodings and counts.
 * Assumes command bytes arrive already deframed from the serial port.
 */
package acrb_pkg;
	localparam int NUM_REGS = 11;
	localparam logic [4:0] IDX_IDENTITY_AND_OFFSET_SELECT = 5'h00;
	localparam logic [4:0] IDX_MAIN_CONFIGURATION = 5'h01;
	localparam logic [4:0] IDX_INPUT_AND_GAIN_CONFIGURATION = 5'h02;
	localparam logic [4:0] IDX_HIGHPASS_CORNER_LOW = 5'h03;
	localparam logic [4:0] IDX_OFFSET_TRIM_LOW = 5'h05;
	localparam logic [4:0] IDX_GAIN_TRIM_LOW = 5'h08;
	localparam logic [4:0] IDX_GAIN_TRIM_HIGH = 5'h0a;

	// reset values, index order 00h..0Ah
	localparam logic [7:0] RST_IDENTITY_AND_OFFSET_SELECT = 8'h00;
	localparam logic [7:0] RST_MAIN_CONFIGURATION = 8'h52;
	localparam logic [7:0] RST_INPUT_AND_GAIN_CONFIGURATION = 8'h08;
	localparam logic [7:0] RST_HIGHPASS_CORNER_LOW = 8'h32;
	localparam logic [7:0] RST_HIGHPASS_CORNER_HIGH = 8'h03;
	localparam logic [7:0] RST_TRIM_ZERO = 8'h00;
	localparam logic [7:0] RST_GAIN_TRIM_HIGH = 8'h40;
	localparam logic [7:0] RST_VALUES [NUM_REGS] = '{
		RST_IDENTITY_AND_OFFSET_SELECT, RST_MAIN_CONFIGURATION, RST_INPUT_AND_GAIN_CONFIGURATION,
		RST_HIGHPASS_CORNER_LOW, RST_HIGHPASS_CORNER_HIGH, RST_TRIM_ZERO, RST_TRIM_ZERO,
		RST_TRIM_ZERO, RST_TRIM_ZERO, RST_TRIM_ZERO, RST_GAIN_TRIM_HIGH};

	// field positions
	localparam int POS_IDENTITY_NIBBLE = 4;
	localparam int POS_OFFSET_SELECT = 0;
	localparam int POS_SYNC_STYLE = 7;
	localparam int POS_POWER_MODE = 6;
	localparam int POS_OUTPUT_RATE_SELECT = 3;
	localparam int POS_FILTER_PHASE = 2;
	localparam int POS_FILTER_PATH_SELECT = 0;
	localparam int POS_INPUT_SELECT = 4;
	localparam int POS_CHOP = 3;
	localparam int POS_AMPLIFIER_GAIN = 0;

	// command encodings
	localparam logic [2:0] OPC_REGISTER_READ_COMMAND = 3'h1;
	localparam logic [2:0] OPC_REGISTER_WRITE_COMMAND = 3'h2;
	localparam logic [7:0] OPC_GAIN_CAL_COMMAND = 8'h61;

	// readings discarded after a conversion restart
	localparam int DISCARD_READINGS = 63;

	// offset select codes
	localparam logic [1:0] OFS_DISABLED = 2'h0;
	localparam logic [1:0] OFS_100MV = 2'h2;
	localparam logic [1:0] OFS_75MV = 2'h3;

	// output rate codes and the rates they give, samples per second
	localparam logic [2:0] RATE_250 = 3'h0;
	localparam logic [2:0] RATE_500 = 3'h1;
	localparam logic [2:0] RATE_1000 = 3'h2;
	localparam logic [2:0] RATE_2000 = 3'h3;
	localparam logic [2:0] RATE_4000 = 3'h4;
	localparam logic [12:0] SPS_250 = 13'h00fa;
	localparam logic [12:0] SPS_500 = 13'h01f4;
	localparam logic [12:0] SPS_1000 = 13'h03e8;
	localparam logic [12:0] SPS_2000 = 13'h07d0;
	localparam logic [12:0] SPS_4000 = 13'h0fa0;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RD_COUNT = 3'b001,
		ST_RD_DATA = 3'b010,
		ST_WR_COUNT = 3'b011,
		ST_WR_DATA = 3'b100,
		ST_CAL = 3'b101
	} acrb_state_t;
endpackage

/* hw/acrb_discard_gate.sv */
/*
 * Counts readings discarded after a conversion restart and flags when
 * results are valid again. Assumes one reading_strobe per finished reading.
 */
`timescale 1ns/100ps
`default_nettype none
module acrb_discard_gate #(
	parameter int DISCARD = acrb_pkg::DISCARD_READINGS
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic restart,
	input wire logic reading_strobe,
	output logic readings_valid
);
	logic [6:0] left_reg;

	// restart wins over a reading in the same cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_b)
			left_reg <= 7'(DISCARD);
		else if (restart)
			left_reg <= 7'(DISCARD);
		else if (reading_strobe && left_reg != 7'h00)
			left_reg <= left_reg - 7'h01;
	end

	assign readings_valid = (left_reg == 7'h00) && !restart;
endmodule // acrb_discard_gate
`default_nettype wire

/* hw/acrb_register_bank.sv */
/*
 * Configuration register bank with its command byte parser, gain
 * calibration hand-off and conversion restart after writes.
 * Assumes command bytes arrive deframed, spaced by the host, synchronous.
 */
`timescale 1ns/100ps
`default_nettype none
module acrb_register_bank #(
	parameter logic [3:0] IDENTITY = 4'h5 // arbitrary value
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_byte,
	input wire logic rd_req,
	output logic rd_valid,
	output logic [7:0] rd_byte,
	output logic gain_cal_start,
	input wire logic gain_cal_done,
	input wire logic [23:0] gain_cal_result,
	output logic conv_restart,
	input wire logic reading_strobe,
	output logic readings_valid,
	output logic [1:0] offset_select,
	output logic offset_enable,
	output logic offset_is_75mv,
	output logic sync_continuous,
	output logic high_resolution,
	output logic [2:0] output_rate_select,
	output logic [12:0] rate_sps,
	output logic rate_valid,
	output logic min_phase,
	output logic [1:0] filter_path_select,
	output logic [2:0] input_select,
	output logic chop_enable,
	output logic [2:0] amplifier_gain,
	output logic [15:0] highpass_corner_word,
	output logic [23:0] offset_trim_word,
	output logic [23:0] gain_trim_word
);
	localparam int N = acrb_pkg::NUM_REGS;

	acrb_pkg::acrb_state_t state_reg;
	logic [4:0] addr_reg;
	logic [4:0] cnt_reg;
	logic [7:0] regs_reg [N];
	logic [7:0] rd_mux;
	logic wr_en;
	logic last_byte;
	logic cal_load;
	logic rd_go;
	logic [4:0] rd_addr_q;

	// ************************************************
	// command parser
	// ************************************************
	assign last_byte = (cnt_reg == 5'h00);
	assign wr_en = (state_reg == acrb_pkg::ST_WR_DATA) && cmd_valid;
	assign cal_load = (state_reg == acrb_pkg::ST_CAL) && gain_cal_done;
	assign rd_go = (state_reg == acrb_pkg::ST_RD_DATA) && rd_req;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			state_reg <= acrb_pkg::ST_IDLE;
			addr_reg <= 5'h00;
			cnt_reg <= 5'h00;
		end else begin
			case (state_reg)
				acrb_pkg::ST_IDLE: begin
					if (cmd_valid) begin
						addr_reg <= cmd_byte[4:0];
						if (cmd_byte[7:5] == acrb_pkg::OPC_REGISTER_READ_COMMAND)
							state_reg <= acrb_pkg::ST_RD_COUNT;
						else if (cmd_byte[7:5] == acrb_pkg::OPC_REGISTER_WRITE_COMMAND)
							state_reg <= acrb_pkg::ST_WR_COUNT;
						else if (cmd_byte == acrb_pkg::OPC_GAIN_CAL_COMMAND)
							state_reg <= acrb_pkg::ST_CAL;
					end
				end
				acrb_pkg::ST_RD_COUNT: begin
					if (cmd_valid) begin
						cnt_reg <= cmd_byte[4:0];
						state_reg <= acrb_pkg::ST_RD_DATA;
					end
				end
				acrb_pkg::ST_WR_COUNT: begin
					if (cmd_valid) begin
						cnt_reg <= cmd_byte[4:0];
						state_reg <= acrb_pkg::ST_WR_DATA;
					end
				end
				acrb_pkg::ST_RD_DATA, acrb_pkg::ST_WR_DATA: begin
					if (rd_go || wr_en) begin
						addr_reg <= addr_reg + 5'h01;
						cnt_reg <= cnt_reg - 5'h01;
						if (last_byte)
							state_reg <= acrb_pkg::ST_IDLE;
					end
				end
				acrb_pkg::ST_CAL: begin
					// other commands are ignored while calibration runs
					if (gain_cal_done)
						state_reg <= acrb_pkg::ST_IDLE;
				end
				default: state_reg <= acrb_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b)
			gain_cal_start <= 1'b0;
		else
			gain_cal_start <= (state_reg == acrb_pkg::ST_IDLE) && cmd_valid
				&& (cmd_byte == acrb_pkg::OPC_GAIN_CAL_COMMAND);
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b)
			conv_restart <= 1'b0;
		else
			conv_restart <= wr_en && last_byte;
	end

	// ************************************************
	// register storage
	// ************************************************
	// unmapped addresses swallow writes and read as zero
	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_reg
			// split so the calibration slice is only built where it is in range
			if (gi >= int'(acrb_pkg::IDX_GAIN_TRIM_LOW)) begin : g_cal
				always_ff @(posedge ref_clk) begin
					if (!rst_b)
						regs_reg[gi] <= acrb_pkg::RST_VALUES[gi];
					else if (cal_load)
						regs_reg[gi] <= gain_cal_result[8*(gi-int'(acrb_pkg::IDX_GAIN_TRIM_LOW)) +: 8];
					else if (wr_en && addr_reg == 5'(gi))
						regs_reg[gi] <= cmd_byte;
				end
			end else begin : g_plain
				always_ff @(posedge ref_clk) begin
					if (!rst_b)
						regs_reg[gi] <= acrb_pkg::RST_VALUES[gi];
					else if (wr_en && addr_reg == 5'(gi)) begin
						if (gi == int'(acrb_pkg::IDX_IDENTITY_AND_OFFSET_SELECT))
							regs_reg[gi] <= {4'h0, cmd_byte[3:0]};
						else
							regs_reg[gi] <= cmd_byte;
					end
				end
			end
		end
	endgenerate

	always_comb begin
		rd_mux = 8'h00;
		if (addr_reg == acrb_pkg::IDX_IDENTITY_AND_OFFSET_SELECT)
			rd_mux = {IDENTITY, regs_reg[0][3:0]};
		else if (addr_reg <= acrb_pkg::IDX_GAIN_TRIM_HIGH)
			rd_mux = regs_reg[addr_reg[3:0]];
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			rd_valid <= 1'b0;
			rd_byte <= 8'h00;
			rd_addr_q <= 5'h00;
		end else begin
			rd_valid <= rd_go;
			rd_addr_q <= addr_reg;
			if (rd_go)
				rd_byte <= rd_mux;
		end
	end

	// ************************************************
	// decoded configuration
	// ************************************************
	assign offset_select = regs_reg[0][acrb_pkg::POS_OFFSET_SELECT +: 2];
	assign sync_continuous = regs_reg[1][acrb_pkg::POS_SYNC_STYLE];
	assign high_resolution = regs_reg[1][acrb_pkg::POS_POWER_MODE];
	assign output_rate_select = regs_reg[1][acrb_pkg::POS_OUTPUT_RATE_SELECT +: 3];
	assign min_phase = regs_reg[1][acrb_pkg::POS_FILTER_PHASE];
	assign filter_path_select = regs_reg[1][acrb_pkg::POS_FILTER_PATH_SELECT +: 2];
	assign input_select = regs_reg[2][acrb_pkg::POS_INPUT_SELECT +: 3];
	assign chop_enable = regs_reg[2][acrb_pkg::POS_CHOP];
	assign amplifier_gain = regs_reg[2][acrb_pkg::POS_AMPLIFIER_GAIN +: 3];
	assign highpass_corner_word = {regs_reg[4], regs_reg[3]};
	assign offset_trim_word = {regs_reg[7], regs_reg[6], regs_reg[5]};
	assign gain_trim_word = {regs_reg[10], regs_reg[9], regs_reg[8]};

	// reserved offset code behaves as disabled
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			offset_enable <= 1'b0;
			offset_is_75mv <= 1'b0;
		end else begin
			offset_enable <= (offset_select == acrb_pkg::OFS_100MV) || (offset_select == acrb_pkg::OFS_75MV);
			offset_is_75mv <= (offset_select == acrb_pkg::OFS_75MV);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			rate_sps <= acrb_pkg::SPS_1000;
			rate_valid <= 1'b1;
		end else begin
			rate_valid <= 1'b1;
			case (output_rate_select)
				acrb_pkg::RATE_250: rate_sps <= acrb_pkg::SPS_250;
				acrb_pkg::RATE_500: rate_sps <= acrb_pkg::SPS_500;
				acrb_pkg::RATE_1000: rate_sps <= acrb_pkg::SPS_1000;
				acrb_pkg::RATE_2000: rate_sps <= acrb_pkg::SPS_2000;
				acrb_pkg::RATE_4000: rate_sps <= acrb_pkg::SPS_4000;
				default: begin
					rate_sps <= 13'h0000;
					rate_valid <= 1'b0;
				end
			endcase
		end
	end

	acrb_discard_gate #(
		.DISCARD(acrb_pkg::DISCARD_READINGS)
	) u_gate (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.restart(conv_restart),
		.reading_strobe(reading_strobe),
		.readings_valid(readings_valid)
	);

	// ************************************************
	// checks
	// ************************************************
	sequence s_gain_cal_command_cmd;
		state_reg == acrb_pkg::ST_IDLE && cmd_valid && cmd_byte == acrb_pkg::OPC_GAIN_CAL_COMMAND;
	endsequence

	sequence s_cal_done;
		state_reg == acrb_pkg::ST_CAL && gain_cal_done;
	endsequence

	sequence s_wr_last;
		wr_en && last_byte;
	endsequence

	AST_CAL_START: assert property (@(posedge ref_clk) disable iff (!rst_b)
		s_gain_cal_command_cmd |=> gain_cal_start && state_reg == acrb_pkg::ST_CAL)
		else $error("gain calibration opcode not started");
	AST_CAL_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_b)
		s_cal_done |=> gain_trim_word == $past(gain_cal_result) && state_reg == acrb_pkg::ST_IDLE)
		else $error("gain trim word not loaded from calibration");
	AST_RESTART: assert property (@(posedge ref_clk) disable iff (!rst_b)
		s_wr_last |=> conv_restart ##1 !conv_restart)
		else $error("no single restart pulse after write");
	AST_DISCARD: assert property (@(posedge ref_clk) disable iff (!rst_b)
		conv_restart |-> !readings_valid ##1 !readings_valid)
		else $error("readings valid right after restart");
	AST_ID_FIXED: assert property (@(posedge ref_clk) disable iff (!rst_b)
		rd_valid && rd_addr_q == acrb_pkg::IDX_IDENTITY_AND_OFFSET_SELECT |-> rd_byte[7:4] == IDENTITY)
		else $error("identity nibble changed");
	AST_OFFSET: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$stable(offset_select) |=> offset_enable == $past(offset_select[1]) && offset_is_75mv == $past(offset_select == 2'h3))
		else $error("offset select decode wrong");
	AST_MAIN_RESET: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(rst_b) |-> regs_reg[1] == 8'h52 && regs_reg[0][3:0] == 4'h0)
		else $error("configuration reset value wrong");
	AST_RATE: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$stable(output_rate_select) && output_rate_select == 3'h2 |-> rate_sps == 13'h03e8 && rate_valid)
		else $error("rate decode wrong");
	AST_INCR: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(wr_en || rd_go) && !last_byte |=> addr_reg == $past(addr_reg) + 5'h01)
		else $error("burst address did not increment");
endmodule // acrb_register_bank
`default_nettype wire

/* verification/acrb_host_model.sv */
/*
 * Host controller model: sends deframed command bytes and pulls read bytes.
 * Assumes the bank samples on the rising edge of ref_clk.
 */
`timescale 1ns/100ps
`default_nettype none
module acrb_host_model (
	input wire logic ref_clk,
	input wire logic rd_valid,
	input wire logic [7:0] rd_byte,
	output logic cmd_valid,
	output logic [7:0] cmd_byte,
	output logic rd_req
);
	initial begin
		cmd_valid = 1'b0;
		cmd_byte = 8'h00;
		rd_req = 1'b0;
	end

	// gap kept although the bank would take bytes back to back
	task automatic send_byte(input logic [7:0] b);
		repeat (24) @(negedge ref_clk);
		cmd_valid = 1'b1;
		cmd_byte = b;
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		cmd_byte = ~b; // released bus must not show the last byte
	endtask

	task automatic write_open(input logic [4:0] a, input logic [4:0] n);
		send_byte({3'b010, a});
		send_byte({3'b000, n - 5'h01});
	endtask

	task automatic read_open(input logic [4:0] a, input logic [4:0] n);
		send_byte({3'b001, a});
		send_byte({3'b000, n - 5'h01});
	endtask

	task automatic gain_cal();
		send_byte(8'h61);
	endtask

	task automatic read_byte(output logic [7:0] d, output logic v);
		repeat (24) @(negedge ref_clk);
		rd_req = 1'b1;
		@(negedge ref_clk);
		rd_req = 1'b0;
		v = rd_valid;
		d = rd_byte;
	endtask
endmodule // acrb_host_model
`default_nettype wire

/* verification/adc_config_register_bank_tb_top.sv */
/*
 * Top testbench of the configuration register bank: scenarios, compare, verdict.
 * Assumes the host model paces every command byte and read request.
 */
`timescale 1ns/100ps
`default_nettype none
module adc_config_register_bank_tb_top;
	// arbitrary identity nibble, no real part code
	localparam logic [3:0] ID_CODE = 4'ha;
	logic ref_clk, rst_b, cmd_valid, rd_req, rd_valid, gain_cal_start, gain_cal_done;
	logic conv_restart, reading_strobe, readings_valid, offset_enable, offset_is_75mv;
	logic sync_continuous, high_resolution, rate_valid, min_phase;
	logic [7:0] cmd_byte, rd_byte;
	logic [1:0] filter_path_select;
	logic [12:0] rate_sps;
	logic [23:0] gain_cal_result, gain_trim_word;
	logic [1:0] offset_select;
	logic [2:0] output_rate_select, input_select, amplifier_gain;
	logic chop_enable;
	logic [15:0] highpass_corner_word;
	logic [23:0] offset_trim_word;
	int err_count = 0;
	int checks = 0;

	initial ref_clk = 1'b0;
	always #50 ref_clk = ~ref_clk;

	acrb_register_bank #(.IDENTITY(ID_CODE)) i_dut (
		.ref_clk(ref_clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
		.rd_req(rd_req), .rd_valid(rd_valid), .rd_byte(rd_byte), .gain_cal_start(gain_cal_start),
		.gain_cal_done(gain_cal_done), .gain_cal_result(gain_cal_result), .conv_restart(conv_restart),
		.reading_strobe(reading_strobe), .readings_valid(readings_valid), .offset_select(offset_select),
		.offset_enable(offset_enable), .offset_is_75mv(offset_is_75mv), .sync_continuous(sync_continuous),
		.high_resolution(high_resolution), .output_rate_select(output_rate_select), .rate_sps(rate_sps),
		.rate_valid(rate_valid), .min_phase(min_phase), .filter_path_select(filter_path_select),
		.input_select(input_select), .chop_enable(chop_enable), .amplifier_gain(amplifier_gain),
		.highpass_corner_word(highpass_corner_word), .offset_trim_word(offset_trim_word),
		.gain_trim_word(gain_trim_word));

	acrb_host_model i_host (.ref_clk(ref_clk), .rd_valid(rd_valid), .rd_byte(rd_byte),
		.cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .rd_req(rd_req));

	// ****************************************
	// compare and verdict
	// ****************************************
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset_values();
		logic [7:0] d;
		logic v;
		chk(24'(rate_sps), 24'h3e8);
		chk(24'(readings_valid), 24'h0);
		chk(24'(offset_select), 24'h0);
		chk(24'(output_rate_select), 24'h2);
		chk(24'(input_select), 24'h0);
		chk(24'(chop_enable), 24'h1);
		chk(24'(amplifier_gain), 24'h0);
		chk(24'(highpass_corner_word), 24'h0332);
		chk(offset_trim_word, 24'h0);
		i_host.read_byte(d, v);
		chk(24'(v), 24'h0);
		i_host.read_open(5'h00, 5'd12);
		for (int i = 0; i < 12; i++) begin
			i_host.read_byte(d, v);
			chk(24'(v), 24'h1);
			if (i == 0) chk(24'(d), 24'({ID_CODE, 4'h0}));
			else if (i < 11) chk(24'(d), 24'(acrb_pkg::RST_VALUES[i]));
			else chk(24'(d), 24'h0);
		end
	endtask

	// codes 5 and 1 cover the invalid rate and the reserved offset
	task automatic t_fields();
		logic [7:0] d;
		logic v;
		logic [2:0] c;
		for (int i = 0; i < 6; i++) begin
			c = 3'(i);
			i_host.write_open(5'h00, 5'd2);
			i_host.send_byte({4'hf, 2'b00, c[1:0]});
			i_host.send_byte({c[0], c[1], c, c[0], c[1:0]});
			chk(24'(conv_restart), 24'h1);
			repeat (2) @(negedge ref_clk);
			chk(24'(sync_continuous), 24'(c[0]));
			chk(24'(high_resolution), 24'(c[1]));
			chk(24'(min_phase), 24'(c[0]));
			chk(24'(filter_path_select), 24'(c[1:0]));
			chk(24'(output_rate_select), 24'(c));
			chk(24'(offset_select), 24'(c[1:0]));
			chk(24'(offset_enable), 24'(c[1]));
			chk(24'(offset_is_75mv), 24'(c[1:0] == 2'b11));
			chk(24'(rate_valid), 24'(i < 5));
			chk(24'(rate_sps), (i < 5) ? (24'h0fa << i) : 24'h0);
			i_host.read_open(5'h00, 5'd1);
			i_host.read_byte(d, v);
			chk(24'(d), 24'({ID_CODE, 2'b00, c[1:0]}));
		end
	endtask

	task automatic t_discard();
		chk(24'(readings_valid), 24'h0);
		for (int i = 1; i <= 63; i++) begin
			@(negedge ref_clk);
			reading_strobe = 1'b1;
			@(negedge ref_clk);
			reading_strobe = 1'b0;
			if (i >= 62) chk(24'(readings_valid), 24'(i == 63));
		end
	endtask

	task automatic t_gain_cal();
		logic [7:0] d;
		logic v;
		// input assumed settled below full scale before the command
		i_host.gain_cal();
		chk(24'(gain_cal_start), 24'h1);
		i_host.write_open(5'h08, 5'd1);
		@(negedge ref_clk);
		gain_cal_done = 1'b1;
		gain_cal_result = 24'h12_3456;
		@(negedge ref_clk);
		gain_cal_done = 1'b0;
		gain_cal_result = 24'hed_cba9;
		@(negedge ref_clk);
		chk(gain_trim_word, 24'h12_3456);
		chk(24'(readings_valid), 24'h1);
		i_host.read_open(5'h08, 5'd3);
		for (int k = 0; k < 3; k++) begin
			i_host.read_byte(d, v);
			chk(24'(d), (24'h12_3456 >> (8 * k)) & 24'hff);
		end
	endtask

	initial begin
		rst_b = 1'b0;
		gain_cal_done = 1'b0;
		gain_cal_result = 24'h00_0000;
		reading_strobe = 1'b0;
		repeat (3) @(negedge ref_clk);
		rst_b = 1'b1;
		t_reset_values();
		t_fields();
		t_discard();
		t_gain_cal();
		give_verdict();
	end

	// whole run needs under 4000 cycles
	initial begin
		#1000000;
		err_count++;
		give_verdict();
	end
endmodule // adc_config_register_bank_tb_top
`default_nettype wire
